// File: testbench/ids_slot_model.sv
`timescale 1ns/1ps
// slot device: ends each access after wait_i + 1 cycles, drives pads only when told
module ids_slot_model (
    input wire logic clk_i, rst_i, acc_i, drv_i,
    input wire logic [3:0] wait_i,
    input wire logic [1:0] oe_i,
    input wire logic [15:0] val_i, pad_i,
    output logic [15:0] wire_o,
    output logic done_o
);
    logic [3:0] cnt_r;
    logic [15:0] last_r;
    // counter restarts after each pulse so a split access waits again
    always_ff @(posedge clk_i) begin
        cnt_r <= (rst_i || !acc_i || done_o) ? 4'h0 : cnt_r + 4'h1;
        done_o <= !rst_i && acc_i && !done_o && cnt_r == wait_i;
        last_r <= rst_i ? 16'h0000 : wire_o;
    end
    // an undriven half toggles, so a stale value can never pass
    assign wire_o = {oe_i[1] ? pad_i[15:8] : drv_i ? val_i[15:8] : ~last_r[15:8],
                     oe_i[0] ? pad_i[7:0] : drv_i ? val_i[7:0] : ~last_r[7:0]};
endmodule

// File: testbench/ids_steer_sva.sv
`timescale 1ns/1ps
// port-level checks; request fields are held from the taking edge
module ids_steer_sva import ids_pkg::*; (
    input wire logic ref_clk_i, rst_i, start_i, write_i, access_done_i, busy_o, done_o, slot_access_o,
    input wire ids_init_t init_i,
    input wire ids_tgt_t tgt_i,
    input wire logic slot_data_low_oe_o, slot_data_high_oe_o,
    input wire logic [7:0] slot_data_low_o, slot_data_high_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic wr_r;
    ids_init_t in_r;
    ids_tgt_t tg_r;
    wire no_drv = !slot_data_low_oe_o && !slot_data_high_oe_o;
    // copy of the request, since the inputs may move once taken
    always_ff @(posedge ref_clk_i) begin
        if (start_i && !busy_o) begin
            wr_r <= write_i;
            in_r <= init_i;
            tg_r <= tgt_i;
        end
    end
    AST_TAKE: assert property (start_i && !busy_o |=> busy_o) else $error("start not taken");
    AST_LAG: assert property ($rose(busy_o) |=> slot_access_o) else $error("access late");
    AST_DONE: assert property (done_o |-> !busy_o && $past(access_done_i)) else $error("bad done");
    AST_END: assert property ($fell(busy_o) |-> done_o) else $error("busy fell silently");
    AST_ISA_RD: assert property (slot_access_o && !wr_r && in_r == IDS_DMA16 && tg_r != IDS_TGT_PCI
        && tg_r != IDS_TGT_ONCHIP && tg_r != IDS_TGT_PERIPH |-> no_drv) else $error("pads driven on read");
    AST_ISA_WR: assert property (slot_access_o && wr_r && in_r == IDS_DMA16 |-> no_drv)
        else $error("pads driven on write");
    AST_ONCHIP: assert property (slot_access_o && !wr_r && tg_r == IDS_TGT_ONCHIP
        |-> !no_drv && slot_data_low_o == slot_data_high_o) else $error("halves differ");
    AST_PCI_WR: assert property (slot_access_o && wr_r && tg_r == IDS_TGT_PCI |-> no_drv)
        else $error("pads driven toward pci");
endmodule

// File: testbench/ids_steer_tb.sv
`timescale 1ns/1ps
module ids_steer_tb;
    import ids_pkg::*;
    logic ref_clk_i, rst_i, start_i, write_i, word_i, access_done_i, slot_data_low_oe_o, slot_data_high_oe_o;
    logic slot_access_o, busy_o, done_o, drv;
    ids_init_t init_i;
    ids_tgt_t tgt_i;
    logic [1:0] addr_i, oe_q;
    logic [3:0] pci_lane_valid_o, wt;
    logic [7:0] slot_data_low_i, slot_data_high_i, peripheral_byte_bus_i, onchip_data_i, slot_data_low_o;
    logic [7:0] slot_data_high_o, lo_q [2], hi_q [2];
    logic [15:0] val;
    logic [31:0] pci_data_i, pci_data_o, pci_q;
    int err_total = 0, n_tests = 0, nacc;
    ids_steer dut (.*);
    ids_slot_model slot (.clk_i(ref_clk_i), .rst_i(rst_i), .acc_i(slot_access_o), .drv_i(drv), .wait_i(wt),
        .oe_i({slot_data_high_oe_o, slot_data_low_oe_o}), .val_i(val), .pad_i({slot_data_high_o, slot_data_low_o}),
        .wire_o({slot_data_high_i, slot_data_low_i}), .done_o(access_done_i));
    initial begin
        ref_clk_i = 0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer; pads are sampled in each cycle that ends an access
    task automatic xf(input logic w, ids_init_t ini, ids_tgt_t tg, logic [1:0] a, logic wd, logic [15:0] v);
        write_i = w;
        init_i = ini;
        tgt_i = tg;
        addr_i = a;
        word_i = wd;
        val = v;
        drv = (v != 16'h0000);
        nacc = 0;
        start_i = 1;
        @(posedge ref_clk_i) #2 start_i = 0;
        pci_data_i = ~pci_data_i; // only the copy taken at start may be used
        for (int i = 0; i < 90 && !done_o; i++) begin
            if (access_done_i) begin
                lo_q[nacc%2] = slot_data_low_o;
                hi_q[nacc%2] = slot_data_high_o;
                oe_q = {slot_data_high_oe_o, slot_data_low_oe_o};
                pci_q = pci_data_o;
                nacc++;
            end
            @(posedge ref_clk_i) #2;
        end
        if (!done_o) begin
            err_total++;
            complete_run();
        end
        pci_data_i = 32'h4433_2211;
    endtask
    task automatic t_pci_reads();
        xf(0, IDS_DMA8, IDS_TGT_PCI, 2'h1, 1, 0);
        chk(nacc, 2);
        chk({oe_q, lo_q[0], lo_q[1]}, 32'h12233);
        wt = 4'h9;
        xf(0, IDS_DMA16, IDS_TGT_PCI, 2'h3, 0, 0);
        chk({oe_q, nacc[1:0], hi_q[0]}, 32'h944);
        xf(0, IDS_MASTER16, IDS_TGT_PCI, 2'h2, 1, 0);
        chk({nacc[1:0], hi_q[0], lo_q[0]}, 32'h14433);
        xf(0, IDS_MASTER16, IDS_TGT_PCI, 2'h1, 1, 0);
        chk({nacc[1:0], hi_q[0], lo_q[1]}, 32'h22233);
        wt = 4'h3;
    endtask
    task automatic t_to_pci();
        xf(1, IDS_DMA8, IDS_TGT_PCI, 2'h2, 0, 16'h005A);
        chk({pci_lane_valid_o, pci_q[23:16]}, 32'h45A);
        xf(1, IDS_DMA16, IDS_TGT_PCI, 2'h0, 1, 16'hA55A);
        chk(pci_q[15:0], 32'hA55A);
    endtask
    task automatic t_swaps();
        xf(0, IDS_DMA8, IDS_TGT_ISA16, 2'h1, 0, 16'hC300);
        chk({oe_q, lo_q[0]}, 32'h1C3);
        xf(0, IDS_MASTER16, IDS_TGT_ISA8, 2'h1, 0, 16'h003C);
        chk({oe_q, hi_q[0]}, 32'h23C);
        xf(1, IDS_MASTER16, IDS_TGT_ISA8, 2'h1, 0, 16'h9600);
        chk(lo_q[0], 32'h96);
        xf(1, IDS_DMA8, IDS_TGT_ISA16, 2'h1, 0, 16'h0069);
        chk(hi_q[0], 32'h69);
    endtask
    task automatic t_no_drive();
        xf(0, IDS_DMA16, IDS_TGT_ISA16, 2'h0, 1, 16'h1234);
        chk(oe_q, 0);
        xf(1, IDS_DMA16, IDS_TGT_ISA16, 2'h0, 1, 16'h1234);
        chk(oe_q, 0);
        xf(1, IDS_DMA16, IDS_TGT_ONCHIP, 2'h0, 0, 16'h0012);
        chk(oe_q, 0);
    endtask
    task automatic t_internal();
        xf(0, IDS_MASTER16, IDS_TGT_ONCHIP, 2'h0, 0, 0);
        chk({oe_q, hi_q[0], lo_q[0]}, 32'h3B7B7);
        xf(0, IDS_PCI_MASTER, IDS_TGT_PERIPH, 2'h1, 0, 16'hFF00);
        chk(pci_q[15:8], 32'hE1);
        xf(0, IDS_PCI_MASTER, IDS_TGT_ONCHIP, 2'h3, 0, 0);
        chk({pci_q[31:24], hi_q[0], lo_q[0]}, 32'hB7B7B7);
    endtask
    initial begin
        {rst_i, start_i, write_i, word_i, drv, addr_i, val} = 0;
        init_i = IDS_PCI_MASTER;
        tgt_i = IDS_TGT_PCI;
        wt = 4'h3;
        {peripheral_byte_bus_i, onchip_data_i, pci_data_i} = {8'hE1, 8'hB7, 32'h4433_2211};
        rst_i = 1;
        repeat (3) @(posedge ref_clk_i);
        #2 rst_i = 0;
        t_pci_reads();
        t_to_pci();
        t_swaps();
        t_no_drive();
        t_internal();
        complete_run();
    end
endmodule
bind ids_steer ids_steer_sva sva (.*);

// File: verilog/ids_defs.svh
`ifndef IDS_DEFS_SVH
`define IDS_DEFS_SVH
// Functional notes
// RULE1: ignore slot high half on peripheral-bus reads
// RULE2: 8-bit internal reads use internal bus
// RULE3: internal read byte to lane and halves
// RULE4: 8-bit DMA PCI read: lane to low
// RULE5: latch PCI lanes before driving slot
// RULE6: 16-bit byte read: even low, odd high
// RULE7: aligned 16-bit word: one access, pair
// RULE8: misaligned 16-bit word: two accesses
// RULE9: writes to PCI: low/high to lanes
// RULE10: 8-bit DMA odd read: high to low
// RULE11: 16-bit master odd read: low to high
// RULE12: other ISA reads: slot pads three-stated
// RULE13: master internal reads drive both halves
// RULE14: master odd write 8-bit: high to low
// RULE15: 8-bit DMA odd write: low to high
// RULE16: other ISA writes: slot pads input
// RULE17: internal bus writes use input mode
// RULE18: lanes from address; split access follows
`define IDS_LANE_W 8
`define IDS_ZERO_BYTE 8'h00
`define IDS_ZERO_WORD 32'h0000_0000
`endif

// File: verilog/ids_lane_if.sv
`timescale 1ns/1ps
// request of one slot access towards the lane mux
interface ids_lane_if;
    logic [1:0] lane;
    logic pair;
    logic [31:0] pci_data;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    modport ctrl (output lane, output pair, output pci_data, input low_byte, input high_byte);
    modport mux (input lane, input pair, input pci_data, output low_byte, output high_byte);
endinterface

// File: verilog/ids_lane_mux.sv
`timescale 1ns/1ps
`include "ids_defs.svh"
// selects the byte(s) of the latched PCI word for one slot access
module ids_lane_mux (
    ids_lane_if.mux lif
);
    import ids_pkg::*;
    wire [7:0] sel_byte;
    wire [7:0] even_byte;
    wire [7:0] odd_byte;
    // single byte: lane picked by address bits
    assign sel_byte = lif.pci_data[lif.lane*`IDS_LANE_W +: `IDS_LANE_W]; // RULE4
    // even lanes feed low half, odd lanes high half
    assign even_byte = lif.lane[1] ? lif.pci_data[23:16] : lif.pci_data[7:0]; // RULE6
    assign odd_byte = lif.lane[1] ? lif.pci_data[31:24] : lif.pci_data[15:8];
    assign lif.low_byte = lif.pair ? even_byte : (lif.lane[0] ? `IDS_ZERO_BYTE : sel_byte);
    assign lif.high_byte = lif.pair ? odd_byte : (lif.lane[0] ? sel_byte : `IDS_ZERO_BYTE);
endmodule

// File: verilog/ids_pkg.sv
package ids_pkg;
    // who owns the transfer
    typedef enum logic [1:0] {IDS_PCI_MASTER, IDS_DMA8, IDS_DMA16, IDS_MASTER16} ids_init_t;
    // where the target sits
    typedef enum logic [2:0] {IDS_TGT_PCI, IDS_TGT_ISA8, IDS_TGT_ISA16, IDS_TGT_ONCHIP, IDS_TGT_PERIPH} ids_tgt_t;
    typedef enum logic {IDS_IDLE, IDS_SECOND} ids_state_t;
endpackage

// File: verilog/ids_steer.sv
`timescale 1ns/1ps
`include "ids_defs.svh"
// isa data byte steering: one transfer request at a time
module ids_steer (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // transfer request
    input wire logic start_i,
    input wire logic write_i,
    input wire ids_pkg::ids_init_t init_i,
    input wire ids_pkg::ids_tgt_t tgt_i,
    input wire logic [1:0] addr_i,
    input wire logic word_i,
    input wire logic access_done_i,
    // data sources
    input wire logic [31:0] pci_data_i,
    input wire logic [7:0] slot_data_low_i,
    input wire logic [7:0] slot_data_high_i,
    input wire logic [7:0] peripheral_byte_bus_i,
    input wire logic [7:0] onchip_data_i,
    // slot pads
    output logic [7:0] slot_data_low_o,
    output logic [7:0] slot_data_high_o,
    output logic slot_data_low_oe_o,
    output logic slot_data_high_oe_o,
    // pci side
    output logic [31:0] pci_data_o,
    output logic [3:0] pci_lane_valid_o,
    // access control
    output logic slot_access_o,
    output logic busy_o,
    output logic done_o
);
    import ids_pkg::*;
    ids_lane_if lif();
    ids_lane_mux u_mux (.lif(lif));
    ids_state_t state_r, state_nxt;
    logic [31:0] latch_r;
    logic write_r, word_r;
    ids_init_t init_r;
    ids_tgt_t tgt_r;
    logic [1:0] addr_r;
    logic [1:0] lane_r;
    logic [7:0] sl_r, sh_r;
    logic sl_oe_r, sh_oe_r;
    logic [31:0] pci_r;
    logic [3:0] valid_r;
    logic acc_r, busy_r, done_r;
    // decode of the held request
    wire is16 = (init_r == IDS_DMA16) || (init_r == IDS_MASTER16);
    wire tgt_pci = (tgt_r == IDS_TGT_PCI);
    wire tgt_int = (tgt_r == IDS_TGT_ONCHIP) || (tgt_r == IDS_TGT_PERIPH);
    wire odd = lane_r[0];
    // pairing follows the start address, so the tail of a split stays one byte
    wire pair = is16 && word_r && !addr_r[0]; // RULE7
    wire split = word_r && (!is16 || addr_r[0]); // RULE8
    // read byte coming back from an internal bus; high half never used here
    wire [7:0] int_byte = (tgt_r == IDS_TGT_ONCHIP) ? onchip_data_i : peripheral_byte_bus_i; // RULE1 RULE2
    // swap cases between isa slots
    wire rd_swap_hl = !write_r && init_r == IDS_DMA8 && tgt_r == IDS_TGT_ISA16 && odd; // RULE10
    wire rd_swap_lh = !write_r && init_r == IDS_MASTER16 && tgt_r == IDS_TGT_ISA8 && odd; // RULE11
    wire wr_swap_hl = write_r && init_r == IDS_MASTER16 && tgt_r == IDS_TGT_ISA8 && odd; // RULE14
    wire wr_swap_lh = write_r && init_r == IDS_DMA8 && tgt_r == IDS_TGT_ISA16 && odd; // RULE15
    wire pci_rd = !write_r && tgt_pci && init_r != IDS_PCI_MASTER;
    wire int_rd = !write_r && tgt_int;
    // slot pad decode; pads float or listen unless a case drives them
    wire low_oe_w = (pci_rd && (!is16 || pair || !odd)) || int_rd || rd_swap_hl || wr_swap_hl; // RULE12 RULE16 RULE17
    wire high_oe_w = (pci_rd && is16 && (pair || odd)) || int_rd || rd_swap_lh || wr_swap_lh; // RULE13
    // an 8-bit channel only listens on the low half, whatever lane it reads
    wire [7:0] mux_low = (!is16 && odd) ? lif.high_byte : lif.low_byte; // RULE4
    wire [7:0] low_w = int_rd ? int_byte : (rd_swap_hl || wr_swap_hl) ? slot_data_high_i : mux_low; // RULE3
    wire [7:0] high_w = int_rd ? int_byte : (rd_swap_lh || wr_swap_lh) ? slot_data_low_i : lif.high_byte;
    // data toward pci lanes for writes by dma/master and pci-master reads
    wire [31:0] low_rep = {4{slot_data_low_i}};
    wire [31:0] high_rep = {4{slot_data_high_i}};
    wire [7:0] rd_src = int_rd ? int_byte : (odd && tgt_r == IDS_TGT_ISA16) ? slot_data_high_i : slot_data_low_i;
    wire [31:0] byte_word = {4{rd_src}};
    wire [31:0] pci_w = pair ? {high_rep[31:24], low_rep[23:16], high_rep[15:8], low_rep[7:0]} : // RULE9
                        (is16 && odd && write_r) ? high_rep : (write_r ? low_rep : byte_word);
    wire [3:0] lane_one = 4'h1 << lane_r;
    wire [3:0] lane_two = lane_r[1] ? 4'hC : 4'h3;
    wire to_pci = (write_r && tgt_pci) || (!write_r && init_r == IDS_PCI_MASTER); // RULE3
    wire [3:0] valid_w = to_pci ? (pair ? lane_two : lane_one) : 4'h0;
    assign lif.lane = lane_r;
    assign lif.pair = pair;
    assign lif.pci_data = latch_r;
    // second access of a split follows right after the first
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IDS_IDLE: if (busy_r && access_done_i && split) state_nxt = IDS_SECOND; // RULE18
            IDS_SECOND: if (access_done_i) state_nxt = IDS_IDLE;
        endcase
    end
    // request capture and pci lane latch, taken only when idle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= IDS_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            latch_r <= `IDS_ZERO_WORD;
            write_r <= 1'b0;
            word_r <= 1'b0;
            init_r <= IDS_PCI_MASTER;
            tgt_r <= IDS_TGT_PCI;
            addr_r <= 2'h0;
            lane_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            done_r <= 1'b0;
            if (!busy_r && start_i) begin
                busy_r <= 1'b1;
                latch_r <= pci_data_i; // RULE5
                write_r <= write_i;
                word_r <= word_i;
                init_r <= init_i;
                tgt_r <= tgt_i;
                addr_r <= addr_i;
                lane_r <= addr_i; // RULE18
            end else if (busy_r && access_done_i) begin
                if (state_r == IDS_IDLE && split) begin
                    lane_r <= lane_r + 2'h1;
                end else begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end
    // registered pad and lane outputs
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sl_r <= `IDS_ZERO_BYTE;
            sh_r <= `IDS_ZERO_BYTE;
            sl_oe_r <= 1'b0;
            sh_oe_r <= 1'b0;
            pci_r <= `IDS_ZERO_WORD;
            valid_r <= 4'h0;
            acc_r <= 1'b0;
        end else begin
            sl_r <= low_w;
            sh_r <= high_w;
            sl_oe_r <= busy_r && low_oe_w;
            sh_oe_r <= busy_r && high_oe_w;
            pci_r <= pci_w;
            valid_r <= busy_r ? valid_w : 4'h0;
            acc_r <= busy_r;
        end
    end
    assign slot_data_low_o = sl_r;
    assign slot_data_high_o = sh_r;
    assign slot_data_low_oe_o = sl_oe_r;
    assign slot_data_high_oe_o = sh_oe_r;
    assign pci_data_o = pci_r;
    assign pci_lane_valid_o = valid_r;
    assign slot_access_o = acc_r;
    assign busy_o = busy_r;
    assign done_o = done_r;
endmodule
